//--- core/analog_trim_register_bank.sv
`timescale 1ns/10ps
`include "trim_bank_map.svh"

// Summary of operation
// - bit 7 of the bandgap register enables the bandgap slope trim.
// - bit 5 of the bandgap register requests a higher bandgap slope.
// - bit 4 of the bandgap register requests a lower bandgap slope.
// - bit 3 of the bandgap register enables the current-reference trim.
// - bits 2 to 0 of the bandgap register hold the current-reference code.
// - bit 4 of the sleep register enables loading of the sleep code and lock.
// - once the sleep lock is set, new sleep trim values are refused.
// - device reset clears only the digital copies, locked sleep trim survives.
// - bits 2 to 0 of the sleep register hold the sleep bandgap code.
// - bit 7 of the offset register enables the code held in bits 6 to 4.
// - the offset code maps 000 and 111 to no change and others to steps.
// - bit 3 and bits 2 to 0 of the offset register are spare storage.
// - offsets decode from base 0x0200 blocking and 0x300 non-blocking.
// - on reset the first registers default while a locked sleep register stays.
module analog_trim_register_bank
   import trim_bank_pkg::*;
(
   // clock and device reset
   input  wire logic       core_clk_in,
   input  wire logic       rst_n_in,
   // power-on reset, only a full power cycle clears the locked sleep trim
   input  wire logic       por_n_in,
   // die-to-die register access
   input  wire logic [15:0] addr_in,
   input  wire logic        wr_en_in,
   input  wire logic        rd_en_in,
   input  wire logic [7:0]  wdata_in,
   output logic      [7:0]  rdata_out,
   output logic             rvalid_out,
   // trim values to the analog circuits
   output trim_out_t        trim_out,
   output logic             sleep_bandgap_lock_out,
   output logic             sleep_bandgap_trim_enable_out
);

   // page bytes of both windows, cut from the full base words
   localparam logic [15:0] BLOCKING_BASE_W    = `BLOCKING_BASE;
   localparam logic [15:0] NONBLOCKING_BASE_W = `NONBLOCKING_BASE;
   localparam logic [7:0]  BLOCKING_PAGE      = BLOCKING_BASE_W[15:8];
   localparam logic [7:0]  NONBLOCKING_PAGE   = NONBLOCKING_BASE_W[15:8];

   // offsets and reset words at their register widths
   localparam logic [7:0]  BANDGAP_OFS        = `OFS_BANDGAP_IREF;
   localparam logic [7:0]  SLEEP_OFS          = `OFS_SLEEP_BANDGAP;
   localparam logic [7:0]  OFFSET_OFS         = `OFS_OFFSET_COMP;
   localparam logic [7:0]  BANDGAP_RST_W      = `BANDGAP_IREF_RST;
   localparam logic [7:0]  OFFSET_RST_W       = `OFFSET_COMP_RST;
   localparam logic [7:0]  SLEEP_RST_W        = `SLEEP_BANDGAP_RST;
   localparam logic [4:0]  SLEEP_RST          = SLEEP_RST_W[4:0];

   // address decode and write strobes
   logic       page_hit;
   reg_sel_t   sel;
   logic       bg_wr;
   logic       off_wr;
   logic       slp_wr;
   logic       slp_load;

   // register state
   logic [7:0] bg_q;
   logic [7:0] bg_d;
   logic [7:0] off_q;
   logic [7:0] off_d;
   logic [4:0] slp_q;
   logic [4:0] slp_d;

   // field views of the stored registers
   logic       bandgap_trim_enable;
   logic       bandgap_reg_spare_bit;
   logic       bandgap_slope_increase;
   logic       bandgap_slope_decrease;
   logic       current_ref_trim_enable;
   logic [2:0] current_ref_trim_code;
   logic       sleep_bandgap_trim_enable;
   logic       sleep_bandgap_lock;
   logic [2:0] sleep_bandgap_trim_code;
   logic       offset_trim_enable;
   logic [2:0] offset_trim_code;
   logic       offset_reg_spare_enable;
   logic [2:0] offset_spare_bits;

   // read port and output next values
   logic [7:0] rdata_d;
   logic       rvalid_d;
   trim_out_t  trim_d;
   logic       lock_d;
   logic       slp_en_d;

   // either address window hits the same registers
   always_comb begin
      logic [7:0] ofs;
      ofs      = addr_in[7:0];
      page_hit = (addr_in[15:8] == BLOCKING_PAGE) ||
                 (addr_in[15:8] == NONBLOCKING_PAGE);
      sel      = SEL_NONE;
      if (page_hit) begin
         case (ofs)
            BANDGAP_OFS: sel = SEL_BANDGAP;
            SLEEP_OFS:   sel = SEL_SLEEP;
            OFFSET_OFS:  sel = SEL_OFFSET;
            default:     sel = SEL_NONE;
         endcase
      end
   end

   // one strobe per write, so a register takes at most one load a cycle
   always_comb begin
      bg_wr  = 1'b0;
      off_wr = 1'b0;
      slp_wr = 1'b0;
      if (wr_en_in) begin
         case (sel)
            SEL_BANDGAP: bg_wr  = 1'b1;
            SEL_OFFSET:  off_wr = 1'b1;
            SEL_SLEEP:   slp_wr = 1'b1;
            default:     ;
         endcase
      end
   end

   // lock refuses any later load, enable and lock included
   assign slp_load = slp_wr && !sleep_bandgap_lock;

   assign bandgap_trim_enable       = bg_q[`BG_EN_BIT];
   assign bandgap_reg_spare_bit     = bg_q[`BG_SPARE_BIT];
   assign bandgap_slope_increase    = bg_q[`BG_UP_BIT];
   assign bandgap_slope_decrease    = bg_q[`BG_DN_BIT];
   assign current_ref_trim_enable   = bg_q[`IREF_EN_BIT];
   assign current_ref_trim_code     = bg_q[2:0];
   assign sleep_bandgap_trim_enable = slp_q[`SLP_EN_BIT];
   assign sleep_bandgap_lock        = slp_q[`SLP_LOCK_BIT];
   assign sleep_bandgap_trim_code   = slp_q[2:0];
   assign offset_trim_enable        = off_q[`OFF_EN_BIT];
   assign offset_trim_code          = off_q[6:4];
   assign offset_reg_spare_enable   = off_q[`OFF_SPARE_EN_BIT];
   assign offset_spare_bits         = off_q[2:0];

   // bandgap and current-reference register
   always_comb begin
      bg_d = bg_q;
      if (bg_wr) begin
         bg_d[`BG_EN_BIT]    = wdata_in[`BG_EN_BIT];
         bg_d[`BG_SPARE_BIT] = wdata_in[`BG_SPARE_BIT];
         bg_d[`BG_UP_BIT]    = wdata_in[`BG_UP_BIT];
         bg_d[`BG_DN_BIT]    = wdata_in[`BG_DN_BIT];
         bg_d[`IREF_EN_BIT]  = wdata_in[`IREF_EN_BIT];
         bg_d[2:0]           = wdata_in[2:0];
      end
   end

   // digital copy, cleared by device reset
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bg_q <= BANDGAP_RST_W;
      end else begin
         bg_q <= bg_d;
      end
   end

   // offset compensation register, low nibble is spare storage
   always_comb begin
      off_d = off_q;
      if (off_wr) begin
         off_d[`OFF_EN_BIT]       = wdata_in[`OFF_EN_BIT];
         off_d[6:4]               = wdata_in[6:4];
         off_d[`OFF_SPARE_EN_BIT] = wdata_in[`OFF_SPARE_EN_BIT];
         off_d[2:0]               = wdata_in[2:0];
      end
   end

   // digital copy, cleared by device reset
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         off_q <= OFFSET_RST_W;
      end else begin
         off_q <= off_d;
      end
   end

   // device reset is sampled here, so the clear needs one edge while it is low
   always_comb begin
      slp_d = slp_q;
      if (!rst_n_in) begin
         // a locked sleep trim survives device reset
         if (!sleep_bandgap_lock) begin
            slp_d = SLEEP_RST;
         end
      end else if (slp_load) begin
         slp_d[`SLP_EN_BIT] = wdata_in[`SLP_EN_BIT];
         // code and lock load only with the enable set
         if (wdata_in[`SLP_EN_BIT]) begin
            slp_d[`SLP_LOCK_BIT] = wdata_in[`SLP_LOCK_BIT];
            slp_d[2:0]           = wdata_in[2:0];
         end
      end
   end

   // only a power cycle clears a locked sleep trim
   always_ff @(posedge core_clk_in or negedge por_n_in) begin
      if (!por_n_in) begin
         slp_q <= SLEEP_RST;
      end else begin
         slp_q <= slp_d;
      end
   end

   // a read and a write in one cycle return the old value
   always_comb begin
      rdata_d  = 8'h00;
      rvalid_d = rd_en_in;
      if (rd_en_in) begin
         case (sel)
            SEL_BANDGAP: begin
               rdata_d[`BG_EN_BIT]    = bandgap_trim_enable;
               rdata_d[`BG_SPARE_BIT] = bandgap_reg_spare_bit;
               rdata_d[`BG_UP_BIT]    = bandgap_slope_increase;
               rdata_d[`BG_DN_BIT]    = bandgap_slope_decrease;
               rdata_d[`IREF_EN_BIT]  = current_ref_trim_enable;
               rdata_d[2:0]           = current_ref_trim_code;
            end
            SEL_SLEEP: begin
               // bits 7 to 5 read zero
               rdata_d[`SLP_EN_BIT]   = sleep_bandgap_trim_enable;
               rdata_d[`SLP_LOCK_BIT] = sleep_bandgap_lock;
               rdata_d[2:0]           = sleep_bandgap_trim_code;
            end
            SEL_OFFSET: begin
               rdata_d[`OFF_EN_BIT]       = offset_trim_enable;
               rdata_d[6:4]               = offset_trim_code;
               rdata_d[`OFF_SPARE_EN_BIT] = offset_reg_spare_enable;
               rdata_d[2:0]               = offset_spare_bits;
            end
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // read data stands for one cycle after the strobe
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out  <= 8'h00;
         rvalid_out <= 1'b0;
      end else begin
         rdata_out  <= rdata_d;
         rvalid_out <= rvalid_d;
      end
   end

   // disabled trims present neutral codes so stale fields have no effect
   always_comb begin
      trim_d   = '0;
      lock_d   = sleep_bandgap_lock;
      slp_en_d = sleep_bandgap_trim_enable;
      if (bandgap_trim_enable) begin
         trim_d.bandgap_trim_enable    = 1'b1;
         trim_d.bandgap_slope_increase = bandgap_slope_increase;
         trim_d.bandgap_slope_decrease = bandgap_slope_decrease;
      end
      if (current_ref_trim_enable) begin
         trim_d.current_ref_trim_code = current_ref_trim_code;
      end else begin
         trim_d.current_ref_trim_code = `IREF_NEUTRAL;
      end
      if (sleep_bandgap_trim_enable) begin
         trim_d.sleep_bandgap_trim_code = sleep_bandgap_trim_code;
      end else begin
         trim_d.sleep_bandgap_trim_code = `SLEEP_NEUTRAL;
      end
      if (offset_trim_enable) begin
         trim_d.offset_trim_code = offset_trim_code;
      end else begin
         trim_d.offset_trim_code = `OFFSET_NEUTRAL;
      end
   end

   // registered so the analog side never sees decode glitches
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         trim_out <= '0;
      end else begin
         trim_out <= trim_d;
      end
   end

   // status copies drop during device reset and return one edge after release
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sleep_bandgap_lock_out        <= 1'b0;
         sleep_bandgap_trim_enable_out <= 1'b0;
      end else begin
         sleep_bandgap_lock_out        <= lock_d;
         sleep_bandgap_trim_enable_out <= slp_en_d;
      end
   end

endmodule : analog_trim_register_bank

//--- core/trim_bank_map.svh
`ifndef TRIM_BANK_MAP_SVH
`define TRIM_BANK_MAP_SVH

// register offsets within the analog die window
`define BLOCKING_BASE      16'h0200
`define NONBLOCKING_BASE   16'h0300
`define OFS_BANDGAP_IREF   8'hF1
`define OFS_SLEEP_BANDGAP  8'hF2
`define OFS_OFFSET_COMP    8'hF3

// bandgap_iref_trim fields
`define BG_EN_BIT          7
`define BG_SPARE_BIT       6
`define BG_UP_BIT          5
`define BG_DN_BIT          4
`define IREF_EN_BIT        3

// sleep_bandgap_trim fields
`define SLP_EN_BIT         4
`define SLP_LOCK_BIT       3

// offset_comp_trim fields
`define OFF_EN_BIT         7
`define OFF_SPARE_EN_BIT   3

// reset values
`define BANDGAP_IREF_RST   8'h00
`define SLEEP_BANDGAP_RST  8'h00
`define OFFSET_COMP_RST    8'h00

// neutral codes presented while a trim is disabled
`define IREF_NEUTRAL       3'h0
`define SLEEP_NEUTRAL      3'h0
`define OFFSET_NEUTRAL     3'h0

`endif

//--- core/trim_bank_pkg.sv
package trim_bank_pkg;

   typedef struct packed {
      logic       bandgap_trim_enable;
      logic       bandgap_slope_increase;
      logic       bandgap_slope_decrease;
      logic [2:0] current_ref_trim_code;
      logic [2:0] sleep_bandgap_trim_code;
      logic [2:0] offset_trim_code;
   } trim_out_t;

   typedef enum logic [1:0] {
      SEL_NONE,
      SEL_BANDGAP,
      SEL_SLEEP,
      SEL_OFFSET
   } reg_sel_t;

endpackage : trim_bank_pkg

//--- testbench/trim_bank_sva.sv
`timescale 1ns/10ps
module trim_bank_sva
   import trim_bank_pkg::*;
(
   input wire logic        core_clk_in,
   input wire logic        rst_n_in,
   input wire logic [15:0] addr_in,
   input wire logic        wr_en_in,
   input wire logic        rd_en_in,
   input wire logic [7:0]  wdata_in,
   input wire logic [7:0]  rdata_out,
   input wire logic        rvalid_out,
   input wire trim_out_t   trim_out,
   input wire logic        sleep_bandgap_lock_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   wire pg = addr_in[15:9] == 7'h01;
   wire w1 = wr_en_in && pg && addr_in[7:0] == 8'hF1;
   wire w3 = wr_en_in && pg && addr_in[7:0] == 8'hF3;
   wire hit = pg && addr_in[7:0] inside {[8'hF1:8'hF3]};
   read_valid_a: assert property (rvalid_out == $past(rd_en_in)) else $error("rvalid");
   unmapped_zero_a: assert property (rd_en_in && !hit |=> rdata_out == 8'h00)
      else $error("unmapped");
   bg_enable_a: assert property (w1 |-> ##2
      trim_out.bandgap_trim_enable == $past(wdata_in[7], 2)) else $error("bg enable");
   slope_gate_a: assert property (!trim_out.bandgap_trim_enable
      |-> !(trim_out.bandgap_slope_increase | trim_out.bandgap_slope_decrease))
      else $error("slope");
   slope_up_a: assert property (w1 && wdata_in[7]
      |-> ##2 trim_out.bandgap_slope_increase == $past(wdata_in[5], 2)) else $error("slope up");
   iref_code_a: assert property (w1 |-> ##2 trim_out.current_ref_trim_code ==
      ($past(wdata_in[3], 2) ? $past(wdata_in[2:0], 2) : 3'h0)) else $error("iref");
   offset_code_a: assert property (w3 |-> ##2 trim_out.offset_trim_code ==
      ($past(wdata_in[7], 2) ? $past(wdata_in[6:4], 2) : 3'h0)) else $error("offset");
   lock_keep_a: assert property (sleep_bandgap_lock_out |=> sleep_bandgap_lock_out
      && $stable(trim_out.sleep_bandgap_trim_code)) else $error("lock");
endmodule : trim_bank_sva

//--- testbench/mcu_die_model.sv
`timescale 1ns/10ps
module mcu_die_model (
   input  wire logic        core_clk_in,
   input  wire logic [7:0]  rdata_out,
   output logic      [15:0] addr_in,
   output logic             wr_en_in,
   output logic             rd_en_in,
   output logic      [7:0]  wdata_in
);
   initial {addr_in, wr_en_in, rd_en_in, wdata_in} = '0;
   // one strobe cycle, read data taken one edge later
   task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge core_clk_in);
      #1 {addr_in, wr_en_in, rd_en_in, wdata_in} = {a, w, !w, d};
      @(posedge core_clk_in);
      #1 q = rdata_out;
      // released data bus must not keep the old byte
      {wr_en_in, rd_en_in, wdata_in} = {2'b00, ~d};
   endtask : xfer
endmodule : mcu_die_model

//--- testbench/analog_trim_register_bank_tb.sv
`timescale 1ns/10ps
module analog_trim_register_bank_tb;
   import trim_bank_pkg::*;
   logic        core_clk_in = 0;
   logic        rst_n_in = 0;
   logic        por_n_in = 0;
   logic        wr_en_in, rd_en_in, rvalid_out;
   logic        sleep_bandgap_lock_out, sleep_bandgap_trim_enable_out;
   logic [15:0] addr_in;
   logic [7:0]  wdata_in, rdata_out, q;
   trim_out_t   trim_out;
   int          bad_count = 0, n_tests = 0, cyc = 0;
   analog_trim_register_bank dut (
      .core_clk_in                   (core_clk_in),
      .rst_n_in                      (rst_n_in),
      .por_n_in                      (por_n_in),
      .addr_in                       (addr_in),
      .wr_en_in                      (wr_en_in),
      .rd_en_in                      (rd_en_in),
      .wdata_in                      (wdata_in),
      .rdata_out                     (rdata_out),
      .rvalid_out                    (rvalid_out),
      .trim_out                      (trim_out),
      .sleep_bandgap_lock_out        (sleep_bandgap_lock_out),
      .sleep_bandgap_trim_enable_out (sleep_bandgap_trim_enable_out)
   );
   mcu_die_model mcu (
      .core_clk_in (core_clk_in),
      .rdata_out   (rdata_out),
      .addr_in     (addr_in),
      .wr_en_in    (wr_en_in),
      .rd_en_in    (rd_en_in),
      .wdata_in    (wdata_in)
   );
   initial forever #10 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) if (++cyc > 2000) begin
      bad_count++;
      test_done;
   end
   task check(input logic [11:0] s, input logic [11:0] e);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch at %0t: saw %h want %h", $time, s, e);
      end
   endtask : check
   task test_done;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   task rst(input logic p);
      {por_n_in, rst_n_in} = {p, 1'b0};
      repeat (12) @(posedge core_clk_in);
      #1 {por_n_in, rst_n_in} = 2'b11;
   endtask : rst
   task wr(input logic [15:0] a, input logic [7:0] d);
      mcu.xfer(1'b1, a, d, q);
      @(posedge core_clk_in);
      #1;
   endtask : wr
   task rd(input logic [15:0] a, input logic [7:0] e);
      mcu.xfer(1'b0, a, 8'h00, q);
      check(q, e);
   endtask : rd
   task t_bandgap;
      wr(16'h02F1, 8'hBD);
      check(trim_out[11:6], 6'h3D);
      rd(16'h03F1, 8'hBD);
      wr(16'h02F1, 8'h76);
      check(trim_out[11:6], 6'h00);
      $display("bandgap test done");
   endtask : t_bandgap
   task t_offset;
      for (int c = 0; c < 8; c++) begin
         wr(16'h02F3, {1'b1, c[2:0], 1'b1, c[2:0]});
         check(trim_out.offset_trim_code, c[2:0]);
         rd(16'h03F3, {1'b1, c[2:0], 1'b1, c[2:0]});
      end
      wr(16'h02F3, 8'h5F);
      check(trim_out.offset_trim_code, 3'h0);
      $display("offset test done");
   endtask : t_offset
   task t_sleep;
      wr(16'h02F2, 8'h0A);
      rd(16'h02F2, 8'h00);
      wr(16'h02F2, 8'h1D);
      check({sleep_bandgap_trim_enable_out, sleep_bandgap_lock_out,
             trim_out.sleep_bandgap_trim_code}, 5'h1D);
      wr(16'h02F2, 8'h13);
      rd(16'h02F2, 8'h1D);
      rst(1'b1);
      rd(16'h02F2, 8'h1D);
      rd(16'h02F1, 8'h00);
      rst(1'b0);
      rd(16'h02F2, 8'h00);
      rd(16'h02F0, 8'h00);
      rd(16'h04F1, 8'h00);
      $display("sleep test done");
   endtask : t_sleep
   initial begin
      rst(1'b0);
      t_bandgap;
      t_offset;
      t_sleep;
      test_done;
   end
endmodule : analog_trim_register_bank_tb
bind analog_trim_register_bank trim_bank_sva chk (
   .core_clk_in            (core_clk_in),
   .rst_n_in               (rst_n_in),
   .addr_in                (addr_in),
   .wr_en_in               (wr_en_in),
   .rd_en_in               (rd_en_in),
   .wdata_in               (wdata_in),
   .rdata_out              (rdata_out),
   .rvalid_out             (rvalid_out),
   .trim_out               (trim_out),
   .sleep_bandgap_lock_out (sleep_bandgap_lock_out)
);
